// ===== design/event_manager.sv
// second-level event manager: serial 1 flags and mask, missed bits, non-maskable
// sources, auxiliary fault status and the per-interrupt pend latch and mask
// assumes all inputs come from logic on ref_clk; registers behind Avalon-MM
`include "event_manager_defs.svh"

module event_manager #(
  parameter int TOP_WIDTH = 17,
  parameter int SERIAL1_WIDTH = 15,
  parameter int unsigned WDOG_CYCLES = (`WDOG_LOW_WATER_US * 1000) / `CLK_PERIOD_NS
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [SERIAL1_WIDTH-1:0] serial1_events,
  input wire logic [TOP_WIDTH-1:0] periph_request,
  input wire logic [TOP_WIDTH-1:0] periph_missed,
  input wire logic crystal_fail,
  output logic clock_select_rc,
  input wire logic fault_valid,
  input wire event_manager_pkg::access_size_t fault_size,
  input wire logic [1:0] fault_addr_low,
  input wire logic fault_is_apb,
  input wire logic fault_write,
  input wire logic fault_privileged,
  input wire logic fault_system_periph,
  input wire logic fault_protected_ram,
  input wire logic fault_above_last_reg,
  input wire logic fault_above_memory,
  output logic [TOP_WIDTH-1:0] top_irq,
  output logic nmi_request,
  output logic bus_fault,
  output logic hard_fault
);
  import event_manager_pkg::*;

  // reserved top bits never latch, enable or request
  localparam logic [TOP_WIDTH-1:0] TOP_VALID = TOP_WIDTH'(`TOP_VALID_MASK);

  // =====================================================================
  // bus slave: one wait state, write and read data at the acknowledging edge
  logic ack_r;
  logic [31:0] be_mask;
  logic [31:0] wr_ones;
  logic wr_hit;
  logic [31:0] rd_mux;

  assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wr_ones = avs_writedata & be_mask;
  // a write takes effect only at the edge where the master sees waitrequest low
  assign wr_hit = avs_write & ack_r;

  // one strobe per register except the top pend and enable ones, high only at the edge where a write lands
  logic hit_flags;
  logic hit_mask;
  logic hit_nmi;
  logic hit_missed;
  logic hit_fault;
  logic hit_ctrl;

  assign hit_flags = wr_hit && avs_address == `OFS_SERIAL1_FLAGS;
  assign hit_mask = wr_hit && avs_address == `OFS_SERIAL1_MASK;
  assign hit_nmi = wr_hit && avs_address == `OFS_NMI_FLAGS;
  assign hit_missed = wr_hit && avs_address == `OFS_MISSED;
  assign hit_fault = wr_hit && avs_address == `OFS_FAULT_STATUS;
  // control bits all sit in byte lane 0
  assign hit_ctrl = wr_hit && avs_address == `OFS_CONTROL && avs_byteenable[0];

  // waitrequest is low for one cycle; a request still held after it is a new one
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & ~ack_r);
    end
  end

  // =====================================================================
  // serial controller 1 flags and mask
  logic [SERIAL1_WIDTH-1:0] serial1_flags_r;
  logic [SERIAL1_WIDTH-1:0] serial1_mask_r;
  logic [SERIAL1_WIDTH-1:0] serial1_flag_clr;
  logic serial1_req;
  logic serial1_lost;

  assign serial1_flag_clr = hit_flags ? wr_ones[SERIAL1_WIDTH-1:0] : '0;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      serial1_flags_r <= '0;
    end else begin
      // event set wins over a same-cycle clear
      serial1_flags_r <= (serial1_flags_r & ~serial1_flag_clr) | serial1_events;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      serial1_mask_r <= '0;
    end else if (hit_mask) begin
      // ones enable, zeros disable, per written byte lane
      serial1_mask_r <= (serial1_mask_r & ~be_mask[SERIAL1_WIDTH-1:0]) |
                        wr_ones[SERIAL1_WIDTH-1:0];
    end
  end

  // mask only gates; a flag already set shows as soon as it is enabled
  assign serial1_req = |(serial1_flags_r & serial1_mask_r);
  // nothing is counted: a repeat on a set, enabled flag is merged and noted
  assign serial1_lost = |(serial1_events & serial1_flags_r & serial1_mask_r);

  // =====================================================================
  // missed-event bits per top-level peripheral
  logic [TOP_WIDTH-1:0] missed_r;
  logic [TOP_WIDTH-1:0] missed_set;
  logic [TOP_WIDTH-1:0] missed_clr;

  always_comb begin
    // other peripherals judge their own losses; serial 1 is judged here
    missed_set = periph_missed;
    missed_set[`TOP_SERIAL1_BIT] = periph_missed[`TOP_SERIAL1_BIT] | serial1_lost;
    missed_set = missed_set & TOP_VALID;
  end

  assign missed_clr = hit_missed ? wr_ones[TOP_WIDTH-1:0] : '0;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      missed_r <= '0;
    end else begin
      missed_r <= (missed_r & ~missed_clr) | missed_set;
    end
  end

  // =====================================================================
  // crystal failure: switch to the RC clock first, raise the event after
  logic xtal_switched_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      clock_select_rc <= 1'b0;
    end else if (!clock_select_rc && crystal_fail) begin
      clock_select_rc <= 1'b1;
    end else if (hit_ctrl && !avs_writedata[`CTRL_CLOCK_RC_BIT] && !crystal_fail) begin
      // software may return to the crystal only once it runs again
      clock_select_rc <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      xtal_switched_r <= 1'b0;
    end else begin
      // set at the same edge as the switch, so the flag lands one edge after it
      xtal_switched_r <= !clock_select_rc && crystal_fail;
    end
  end

  // =====================================================================
  // watchdog low-water counter
  // the flag lands exactly WDOG_CYCLES edges after enable or restart
  localparam logic [28:0] WDOG_LIMIT = 29'(WDOG_CYCLES);
  logic wdog_enable_r;
  logic [28:0] wdog_cnt_r;
  logic wdog_restart;
  logic wdog_event;

  assign wdog_restart = hit_ctrl && avs_writedata[`CTRL_WDOG_RESTART_BIT];

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wdog_enable_r <= 1'b0;
    end else if (hit_ctrl) begin
      wdog_enable_r <= avs_writedata[`CTRL_WDOG_ENABLE_BIT];
    end
  end

  // the counter halts at the limit so the event fires once per expiry
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wdog_cnt_r <= '0;
    end else if (!wdog_enable_r || wdog_restart) begin
      wdog_cnt_r <= '0;
    end else if (wdog_cnt_r != WDOG_LIMIT) begin
      wdog_cnt_r <= wdog_cnt_r + 29'h1;
    end
  end

  assign wdog_event = wdog_enable_r && !wdog_restart &&
                      wdog_cnt_r == WDOG_LIMIT - 29'h1;

  // =====================================================================
  // non-maskable flags: exactly two sources, no mask
  logic [1:0] nmi_flags_r;
  logic [1:0] nmi_set;
  logic [1:0] nmi_clr;

  always_comb begin
    nmi_set = 2'h0;
    nmi_set[`NMI_CRYSTAL_BIT] = xtal_switched_r;
    nmi_set[`NMI_WATCHDOG_BIT] = wdog_event;
  end

  assign nmi_clr = hit_nmi ? wr_ones[1:0] : 2'h0;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      nmi_flags_r <= 2'h0;
    end else begin
      nmi_flags_r <= (nmi_flags_r & ~nmi_clr) | nmi_set;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      nmi_request <= 1'b0;
    end else begin
      // no mask stands between the two flags and the request
      nmi_request <= |nmi_flags_r;
    end
  end

  // =====================================================================
  // auxiliary fault status
  logic [3:0] fault_status_r;
  logic [3:0] fault_cause;
  logic [3:0] fault_clr;
  logic fault_new;

  always_comb begin
    fault_cause = 4'h0;
    fault_cause[`FAULT_BAD_SIZE_BIT] =
      (fault_is_apb && fault_size != SIZE_WORD) ||
      (fault_size == SIZE_WORD && fault_addr_low != 2'h0);
    fault_cause[`FAULT_PRIVILEGE_BIT] = fault_write && !fault_privileged &&
      (fault_system_periph || fault_protected_ram);
    fault_cause[`FAULT_UNMAPPED_BIT] =
      (fault_is_apb && fault_above_last_reg) || fault_above_memory;
    // causes are trusted only while the fabric qualifies them
    fault_cause = fault_valid ? fault_cause : 4'h0;
  end

  assign fault_new = |fault_cause;
  assign fault_clr = hit_fault ? wr_ones[3:0] : 4'h0;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fault_status_r <= 4'h0;
    end else begin
      // bit 0 marks a fault that met one already recorded
      // several causes of one access are kept together
      fault_status_r <= (fault_status_r & ~fault_clr) | fault_cause |
                        {3'h0, fault_new && (|fault_status_r)};
    end
  end

  // the repeat fault goes to hard fault, which preempts the bus fault
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bus_fault <= 1'b0;
      hard_fault <= 1'b0;
    end else begin
      bus_fault <= fault_new && !(|fault_status_r);
      hard_fault <= fault_new && (|fault_status_r);
    end
  end

  // =====================================================================
  // top-level pend latch and enable mask, one per interrupt
  logic [TOP_WIDTH-1:0] level_req;
  logic [TOP_WIDTH-1:0] pend_r;
  logic [TOP_WIDTH-1:0] enable_r;

  always_comb begin
    // serial 1 is the only peripheral whose flags live in this block
    level_req = periph_request;
    level_req[`TOP_SERIAL1_BIT] = periph_request[`TOP_SERIAL1_BIT] | serial1_req;
    level_req = level_req & TOP_VALID;
  end

  for (genvar i = 0; i < TOP_WIDTH; i++) begin : g_top
    logic pend_set;
    logic pend_clr;
    logic en_set;
    logic en_clr;
    // each bit keeps its own flops, so no vector is written by two processes
    logic pend_bit_r;
    logic enable_bit_r;
    logic irq_bit_r;
    assign pend_set = wr_hit && avs_address == `OFS_TOP_PEND_SET && wr_ones[i];
    assign pend_clr = wr_hit && avs_address == `OFS_TOP_PEND_CLR && wr_ones[i];
    assign en_set = wr_hit && avs_address == `OFS_TOP_ENABLE_SET && wr_ones[i];
    assign en_clr = wr_hit && avs_address == `OFS_TOP_ENABLE_CLR && wr_ones[i];

    always_ff @(posedge ref_clk) begin
      if (srst || !TOP_VALID[i]) begin
        pend_bit_r <= 1'b0;
      end else if (level_req[i] || pend_set) begin
        // a live second-level level keeps the latch from clearing
        pend_bit_r <= 1'b1;
      end else if (pend_clr) begin
        pend_bit_r <= 1'b0;
      end
    end

    // enables change only by their own set and clear writes
    always_ff @(posedge ref_clk) begin
      if (srst || !TOP_VALID[i]) begin
        enable_bit_r <= 1'b0;
      end else if (en_set) begin
        enable_bit_r <= 1'b1;
      end else if (en_clr) begin
        enable_bit_r <= 1'b0;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (srst) begin
        irq_bit_r <= 1'b0;
      end else begin
        irq_bit_r <= pend_bit_r & enable_bit_r;
      end
    end

    assign pend_r[i] = pend_bit_r;
    assign enable_r[i] = enable_bit_r;
    assign top_irq[i] = irq_bit_r;
  end

  // =====================================================================
  // read mux; unmapped offsets read zero and ignore writes
  always_comb begin
    rd_mux = `RESET_ZERO_32;
    case (avs_address)
      `OFS_SERIAL1_FLAGS: rd_mux[SERIAL1_WIDTH-1:0] = serial1_flags_r;
      `OFS_SERIAL1_MASK: rd_mux[SERIAL1_WIDTH-1:0] = serial1_mask_r;
      `OFS_NMI_FLAGS: rd_mux[1:0] = nmi_flags_r;
      `OFS_MISSED: rd_mux[TOP_WIDTH-1:0] = missed_r;
      `OFS_FAULT_STATUS: rd_mux[3:0] = fault_status_r;
      `OFS_TOP_ENABLE_SET: rd_mux[TOP_WIDTH-1:0] = enable_r;
      `OFS_TOP_ENABLE_CLR: rd_mux[TOP_WIDTH-1:0] = enable_r;
      `OFS_TOP_PEND_SET: rd_mux[TOP_WIDTH-1:0] = pend_r;
      `OFS_TOP_PEND_CLR: rd_mux[TOP_WIDTH-1:0] = pend_r;
      `OFS_CONTROL: begin
        rd_mux[`CTRL_WDOG_ENABLE_BIT] = wdog_enable_r;
        rd_mux[`CTRL_CLOCK_RC_BIT] = clock_select_rc;
      end
      default: rd_mux = `RESET_ZERO_32;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      avs_readdata <= `RESET_ZERO_32;
    end else if (avs_read && !ack_r) begin
      // loaded when the request is taken, before a write of the ack edge lands
      avs_readdata <= rd_mux;
    end
  end
endmodule

// ===== design/event_manager_defs.svh
// constants for the second-level event manager: offsets, fields, resets, timing
// assumes inclusion by the top module, the monitor and the bench
//
// Summary of operation
// - all enabled events of one peripheral are ORed into its top request.
// - writing one to an enable bit enables the source, zero disables it.
// - enable bits only gate flags onto the request, never alter flags.
// - writing one to a flag bit clears it; writing zero leaves it.
// - a hardware event always sets its flag, whatever the enable bit.
// - enabling a flag that is already set raises the request at once.
// - requests to the top controller are levels held while enabled flags remain.
// - a top interrupt cannot be unpended while any feeding flag is set.
// - an event coinciding with a software clear leaves the flag set.
// - no counting or queueing; a repeat while flagged merges into one.
// - an enabled event lost on a set flag sets the peripheral's missed bit.
// - writing one to a missed bit clears it; writing zero does nothing.
// - serial controller 1 flags bits 14..0 feed top-level bit 5.
// - the non-maskable request comes only from crystal failure and watchdog.
// - crystal failure on crystal clock switches to RC clock, then raises event.
// - active watchdog unrestarted for 1.792 s raises its low-water event.
// - bus-fault causes are kept in the auxiliary fault status; several at once.
// - 8/16-bit peripheral access or unaligned 32-bit access flags bad size.
// - unprivileged write to system peripheral or protected RAM flags privilege fault.
// - access above last register in a 4 kB block or above memory flags unmapped.
// - a fault while one is recorded sets the repeat bit and raises hard fault.
// - pend set/clear drive a latch per interrupt, enable set/clear mask its output.
`ifndef EVENT_MANAGER_DEFS_SVH
`define EVENT_MANAGER_DEFS_SVH

// =====================================================================
// register byte offsets
`define OFS_SERIAL1_FLAGS 6'h00
`define OFS_SERIAL1_MASK 6'h04
`define OFS_NMI_FLAGS 6'h08
`define OFS_MISSED 6'h0C
`define OFS_FAULT_STATUS 6'h10
`define OFS_TOP_ENABLE_SET 6'h14
`define OFS_TOP_ENABLE_CLR 6'h18
`define OFS_TOP_PEND_SET 6'h1C
`define OFS_TOP_PEND_CLR 6'h20
`define OFS_CONTROL 6'h24

// =====================================================================
// field positions
`define TOP_SERIAL1_BIT 5
`define TOP_VALID_MASK 17'h1D7BC
`define NMI_CRYSTAL_BIT 0
`define NMI_WATCHDOG_BIT 1
`define FAULT_REPEAT_BIT 0
`define FAULT_UNMAPPED_BIT 1
`define FAULT_PRIVILEGE_BIT 2
`define FAULT_BAD_SIZE_BIT 3
`define CTRL_WDOG_ENABLE_BIT 0
`define CTRL_WDOG_RESTART_BIT 1
`define CTRL_CLOCK_RC_BIT 2

// =====================================================================
// reset values and timing
`define RESET_ZERO_32 32'h0000_0000
`define WDOG_LOW_WATER_US 1792000
`define CLK_PERIOD_NS 4

`endif

// ===== design/event_manager_pkg.sv
// types shared by the event manager and its bench
// takes nothing from event_manager_defs.svh; the size codes are literal
package event_manager_pkg;
  // =====================================================================
  // width of a faulting bus access as reported by the fabric
  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_HALF = 2'h1,
    SIZE_WORD = 2'h2
  } access_size_t;
endpackage

// ===== sim/event_manager_monitor.sv
// checker for event_manager: request, fault and clock-switch timing at the ports
// assumes one clock domain (ref_clk); attached to every event_manager by bind
`include "event_manager_defs.svh"
module event_manager_monitor #(
  parameter int TOP_WIDTH = 17
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic avs_write,
  input wire logic crystal_fail,
  input wire logic clock_select_rc,
  input wire logic fault_valid,
  input wire logic [TOP_WIDTH-1:0] top_irq,
  input wire logic nmi_request,
  input wire logic bus_fault,
  input wire logic hard_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  // ===================================================================
  // reset and requests
  reset_clear_a: assert property (srst |=> top_irq == '0 && !nmi_request
    && !bus_fault && !hard_fault && !clock_select_rc)
    else $error("outputs not cleared by reset");
  valid_bits_a: assert property (disable iff (srst)
    (top_irq & ~TOP_WIDTH'(`TOP_VALID_MASK)) == '0)
    else $error("request on a reserved top bit");
  // a request only drops after software wrote a clear, since it is a level
  serial_hold_a: assert property (disable iff (srst)
    $fell(top_irq[5]) && !$past(srst) |-> $past(avs_write, 2) || $past(avs_write, 3))
    else $error("serial request dropped without a write");
  crystal_switch_a: assert property (disable iff (srst)
    crystal_fail && !clock_select_rc |=> clock_select_rc ##[1:2] nmi_request)
    else $error("crystal failure not switched and raised");
  rc_hold_a: assert property (disable iff (srst)
    $fell(clock_select_rc) && !$past(srst) |-> $past(avs_write) && !$past(crystal_fail))
    else $error("clock left the rc source on its own");
  // ===================================================================
  // bus faults
  fault_answer_a: assert property (disable iff (srst)
    fault_valid |=> bus_fault ^ hard_fault)
    else $error("fault not answered by exactly one pulse");
  bus_cause_a: assert property (disable iff (srst) bus_fault |-> $past(fault_valid))
    else $error("bus fault without a faulting access");
  hard_cause_a: assert property (disable iff (srst) hard_fault |-> $past(fault_valid))
    else $error("hard fault without a faulting access");
  bus_single_a: assert property (disable iff (srst) bus_fault |=> !bus_fault)
    else $error("second fault raised a bus fault");
endmodule

bind event_manager event_manager_monitor #(.TOP_WIDTH(TOP_WIDTH)) i_event_manager_monitor (
  .ref_clk(ref_clk), .srst(srst), .avs_write(avs_write), .crystal_fail(crystal_fail),
  .clock_select_rc(clock_select_rc), .fault_valid(fault_valid), .top_irq(top_irq),
  .nmi_request(nmi_request), .bus_fault(bus_fault), .hard_fault(hard_fault));

// ===== sim/vector_controller_model.sv
// top-level controller model: records every request level it sees
// assumes ref_clk domain; cleared only by srst
module vector_controller_model (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [16:0] top_irq,
  input wire logic nmi_request,
  output logic [16:0] taken_r,
  output logic nmi_taken_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // requests are levels: one sampled high is taken, no edge is needed
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      taken_r <= '0;
      nmi_taken_r <= 1'h0;
    end else begin
      taken_r <= taken_r | top_irq;
      nmi_taken_r <= nmi_taken_r | nmi_request;
    end
  end
endmodule

// ===== sim/event_manager_bench.sv
// self-checking bench for event_manager beside a top-level controller model
// assumes WDOG_CYCLES shortened to 20 and registers behind Avalon-MM
`include "event_manager_defs.svh"
module event_manager_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import event_manager_pkg::*;
  logic ref_clk = 1'h0;
  logic srst = 1'h1;
  logic [5:0] avs_address = '0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata, rdata;
  logic avs_waitrequest, clock_select_rc, nmi_request, bus_fault, hard_fault, nmi_taken_r;
  logic [14:0] serial1_events = '0;
  logic [16:0] periph_request = '0;
  logic [16:0] periph_missed = '0;
  logic [16:0] top_irq, taken_r;
  logic crystal_fail = 1'h0;
  logic fault_valid = 1'h0;
  access_size_t fault_size = SIZE_WORD;
  logic [1:0] fault_addr_low = '0;
  logic [6:0] kind = '0;
  int miscompares = 0;
  int checked = 0;

  event_manager #(.WDOG_CYCLES(20)) i_event_manager (
    .ref_clk(ref_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .serial1_events(serial1_events), .periph_request(periph_request),
    .periph_missed(periph_missed), .crystal_fail(crystal_fail),
    .clock_select_rc(clock_select_rc), .fault_valid(fault_valid), .fault_size(fault_size),
    .fault_addr_low(fault_addr_low), .fault_is_apb(kind[6]), .fault_write(kind[5]),
    .fault_privileged(kind[4]), .fault_system_periph(kind[3]),
    .fault_protected_ram(kind[2]), .fault_above_last_reg(kind[1]),
    .fault_above_memory(kind[0]), .top_irq(top_irq), .nmi_request(nmi_request),
    .bus_fault(bus_fault), .hard_fault(hard_fault));
  vector_controller_model i_vector_controller_model (.ref_clk(ref_clk), .srst(srst),
    .top_irq(top_irq), .nmi_request(nmi_request), .taken_r(taken_r),
    .nmi_taken_r(nmi_taken_r));

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  // ===================================================================
  // shared tasks
  task automatic wrap_up();
    if (miscompares == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // ev rides along the request so that an event can meet a clear at the ack edge
  task automatic bus(input logic rw, input logic [5:0] a, input logic [31:0] d,
    input logic [14:0] ev);
    @(posedge ref_clk);
    avs_read <= !rw;
    avs_write <= rw;
    avs_address <= a;
    avs_writedata <= d;
    serial1_events <= ev;
    for (int i = 0; i <= 50; i++) begin
      @(posedge ref_clk);
      if (!avs_waitrequest) break;
      if (i == 50) begin
        miscompares++;
        wrap_up();
      end
    end
    rdata = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    serial1_events <= '0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [14:0] ev = '0);
    bus(1'h1, a, d, ev);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] want);
    bus(1'h0, a, '0, '0);
    chk(rdata, want);
  endtask
  task automatic pulse(input logic [14:0] ev);
    @(posedge ref_clk);
    serial1_events <= ev;
    @(posedge ref_clk);
    serial1_events <= '0;
  endtask
  task automatic flt(input access_size_t sz, input logic [1:0] al, input logic [6:0] k,
    input int hold, input logic [31:0] want);
    @(posedge ref_clk);
    fault_valid <= 1'h1;
    fault_size <= sz;
    fault_addr_low <= al;
    kind <= k;
    cyc(hold);
    fault_valid <= 1'h0;
    @(posedge ref_clk);
    chk({hard_fault, bus_fault}, (hold == 1) ? 32'h1 : 32'h2);
    rdc(`OFS_FAULT_STATUS, want);
    wr(`OFS_FAULT_STATUS, 32'hF);
  endtask
  // ===================================================================
  // scenarios
  task automatic t_reset();
    rdc(`OFS_SERIAL1_FLAGS, 32'h0);
    rdc(`OFS_SERIAL1_MASK, 32'h0);
    rdc(`OFS_MISSED, 32'h0);
    rdc(`OFS_FAULT_STATUS, 32'h0);
    wr(6'h3C, 32'hFFFF_FFFF);
    rdc(6'h3C, 32'h0);
  endtask
  task automatic t_serial();
    wr(`OFS_TOP_ENABLE_SET, 32'h20);
    pulse(15'h8);
    cyc(4);
    chk(top_irq, 32'h0);
    rdc(`OFS_SERIAL1_FLAGS, 32'h8);
    wr(`OFS_SERIAL1_MASK, 32'h8);
    cyc(4);
    chk(top_irq, 32'h20);
    chk(taken_r, 32'h20);
    wr(`OFS_SERIAL1_FLAGS, 32'h7FF7);
    rdc(`OFS_SERIAL1_FLAGS, 32'h8);
    pulse(15'h8);
    rdc(`OFS_MISSED, 32'h20);
    rdc(`OFS_SERIAL1_FLAGS, 32'h8);
    wr(`OFS_SERIAL1_FLAGS, 32'h8, 15'h8);
    rdc(`OFS_SERIAL1_FLAGS, 32'h8);
    wr(`OFS_TOP_PEND_CLR, 32'h20);
    cyc(4);
    chk(top_irq, 32'h20);
    wr(`OFS_SERIAL1_FLAGS, 32'h8);
    rdc(`OFS_SERIAL1_FLAGS, 32'h0);
    cyc(2);
    wr(`OFS_TOP_PEND_CLR, 32'h20);
    cyc(4);
    chk(top_irq, 32'h0);
    wr(`OFS_MISSED, 32'h0);
    rdc(`OFS_MISSED, 32'h20);
    wr(`OFS_MISSED, 32'h20);
    rdc(`OFS_MISSED, 32'h0);
    wr(`OFS_SERIAL1_MASK, 32'h0);
    pulse(15'h4008);
    cyc(4);
    chk(top_irq, 32'h0);
    wr(`OFS_SERIAL1_FLAGS, 32'h7FFF);
    wr(`OFS_SERIAL1_MASK, 32'h7FFF);
    for (int i = 0; i < 15; i++) begin
      pulse(15'(1 << i));
      rdc(`OFS_SERIAL1_FLAGS, 32'(1 << i));
      chk(top_irq[5], 32'h1);
      wr(`OFS_SERIAL1_FLAGS, 32'(1 << i));
      cyc(2);
      wr(`OFS_TOP_PEND_CLR, 32'h20);
    end
  endtask
  task automatic t_top();
    wr(`OFS_TOP_PEND_SET, 32'h8);
    cyc(4);
    chk(top_irq, 32'h0);
    wr(`OFS_TOP_ENABLE_SET, 32'h8);
    cyc(4);
    chk(top_irq, 32'h8);
    wr(`OFS_TOP_ENABLE_CLR, 32'h8);
    wr(`OFS_TOP_PEND_CLR, 32'h8);
    rdc(`OFS_TOP_PEND_SET, 32'h0);
    periph_request <= 17'h4;
    wr(`OFS_TOP_ENABLE_SET, 32'h4);
    wr(`OFS_TOP_PEND_CLR, 32'h4);
    cyc(4);
    chk(top_irq, 32'h4);
    periph_request <= 17'h0;
    cyc(2);
    wr(`OFS_TOP_PEND_CLR, 32'h4);
    cyc(4);
    chk(top_irq, 32'h0);
    periph_missed <= 17'h80;
    cyc(1);
    periph_missed <= 17'h0;
    rdc(`OFS_MISSED, 32'h80);
  endtask
  task automatic t_nmi();
    crystal_fail <= 1'h1;
    cyc(6);
    chk({clock_select_rc, nmi_request, nmi_taken_r}, 32'h7);
    rdc(`OFS_NMI_FLAGS, 32'h1);
    crystal_fail <= 1'h0;
    wr(`OFS_CONTROL, 32'h0);
    wr(`OFS_NMI_FLAGS, 32'h1);
    cyc(4);
    chk({clock_select_rc, nmi_request}, 32'h0);
    wr(`OFS_CONTROL, 32'h1);
    cyc(12);
    wr(`OFS_CONTROL, 32'h3);
    cyc(12);
    chk(nmi_request, 32'h0);
    cyc(12);
    chk(nmi_request, 32'h1);
    rdc(`OFS_NMI_FLAGS, 32'h2);
    wr(`OFS_CONTROL, 32'h0);
  endtask
  task automatic t_fault();
    flt(SIZE_BYTE, 2'h0, 7'h50, 1, 32'h8);
    flt(SIZE_HALF, 2'h0, 7'h70, 1, 32'h8);
    flt(SIZE_WORD, 2'h2, 7'h10, 1, 32'h8);
    flt(SIZE_WORD, 2'h0, 7'h28, 1, 32'h4);
    flt(SIZE_WORD, 2'h0, 7'h24, 1, 32'h4);
    flt(SIZE_WORD, 2'h0, 7'h52, 1, 32'h2);
    flt(SIZE_WORD, 2'h0, 7'h11, 1, 32'h2);
    flt(SIZE_BYTE, 2'h0, 7'h6A, 1, 32'hE);
    flt(SIZE_WORD, 2'h0, 7'h11, 2, 32'h3);
  endtask
  task automatic t_again();
    wr(`OFS_TOP_PEND_SET, 32'h8);
    wr(`OFS_TOP_ENABLE_SET, 32'h8);
    srst <= 1'h1;
    cyc(2);
    srst <= 1'h0;
    cyc(1);
    chk(top_irq, 32'h0);
    rdc(`OFS_TOP_PEND_SET, 32'h0);
  endtask
  initial begin
    cyc(2);
    srst <= 1'h0;
    t_reset();
    t_serial();
    t_top();
    t_nmi();
    t_fault();
    t_again();
    wrap_up();
  end
endmodule
